// [src/tsens_pkg.sv]
// Shared constants, command codes and state types of the thermal sensor command block.
package tsens_pkg;

  // ****************************************************************
  // Bus addresses and command codes
  // ****************************************************************
  localparam logic [6:0] OWN_ADDR              = 7'h4d;
  localparam logic [6:0] ARA_ADDR              = 7'h0c;
  localparam logic [7:0] ARA_REPLY             = 8'h9b;
  localparam logic [7:0] RESERVED_CMD          = 8'h00;
  localparam logic [7:0] READ_TEMP_CMD         = 8'h01;
  localparam logic [7:0] READ_STATUS_CMD       = 8'h02;
  localparam logic [7:0] READ_CONFIG_CMD       = 8'h03;
  localparam logic [7:0] READ_RATE_CMD         = 8'h04;
  localparam logic [7:0] READ_HIGH_LIMIT_CMD   = 8'h07;
  localparam logic [7:0] READ_LOW_LIMIT_CMD    = 8'h08;
  localparam logic [7:0] WRITE_CONFIG_CMD      = 8'h09;
  localparam logic [7:0] WRITE_RATE_CMD        = 8'h0a;
  localparam logic [7:0] WRITE_HIGH_LIMIT_CMD  = 8'h0d;
  localparam logic [7:0] WRITE_LOW_LIMIT_CMD   = 8'h0e;
  localparam logic [7:0] SINGLE_CONVERSION_CMD = 8'h0f;

  // ****************************************************************
  // Field positions, values after reset and the rate limit
  // ****************************************************************
  localparam int         ST_BUSY_BIT  = 7;
  localparam int         ST_HIGH_BIT  = 4;
  localparam int         ST_LOW_BIT   = 3;
  localparam int         ST_OPEN_BIT  = 2;
  localparam int         STANDBY_BIT  = 6;
  localparam logic [7:0] CONFIG_RST   = 8'h00;
  localparam logic [7:0] RATE_RST     = 8'h02;
  localparam logic [7:0] HIGH_RST     = 8'h7f;
  localparam logic [7:0] LOW_RST      = 8'hc9;
  localparam logic [7:0] TEMP_RST     = 8'h00;
  localparam logic [7:0] RATE_MAX     = 8'h07;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned RATE_TICK_MS = 125;
  localparam int unsigned REF_CLK_KHZ  = 250000;
  localparam int unsigned TICK_CYC_DEF = RATE_TICK_MS * REF_CLK_KHZ;

  // ****************************************************************
  // Crossing bit positions
  // ****************************************************************
  localparam int TOG_CMD   = 0;
  localparam int TOG_WR    = 1;
  localparam int TOG_RD    = 2;
  localparam int TOG_ARA   = 3;
  localparam int PIN_SCL   = 0;
  localparam int PIN_SDA   = 1;
  localparam int PIN_RST   = 2;
  localparam int PIN_RDACK = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {LS_IDLE, LS_ADDR, LS_ACK, LS_RX, LS_TX, LS_WAIT} tsens_lstate_t;

  typedef struct packed {
    logic       done;
    logic       open;
    logic [7:0] temp;
  } tsens_conv_t;

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] stable;
  } tsens_sync_t;

  typedef struct packed {
    tsens_lstate_t state;
    logic [3:0]    bitcnt;
    logic [7:0]    shift;
    logic [7:0]    tx;
    logic [7:0]    cmd_byte;
    logic [7:0]    wr_byte;
    logic [3:0]    tog;
    logic          rdack_seen;
    logic          is_read;
    logic          first;
    logic          ack_drive;
    logic          scl_d;
    logic          sda_d;
    logic          sda_o;
    logic          sda_oe;
  } tsens_lnk_t;

  typedef struct packed {
    logic [7:0]  config_reg;
    logic [7:0]  rate;
    logic [7:0]  high_lim;
    logic [7:0]  low_lim;
    logic [7:0]  temp;
    logic [7:0]  cmd;
    logic [7:0]  rd_data;
    logic        rd_ack;
    logic        alarm_hi;
    logic        alarm_lo;
    logic        open_flag;
    logic        busy;
    logic        alert_n;
    logic [3:0]  seen;
    logic [31:0] tick_cnt;
    logic [7:0]  slot_cnt;
  } tsens_ref_t;

  localparam tsens_lnk_t LNK_RST = '{state: LS_IDLE, scl_d: 1'b1, sda_d: 1'b1, default: '0};
  localparam tsens_ref_t REF_RST = '{config_reg: CONFIG_RST, rate: RATE_RST,
                                     high_lim: HIGH_RST, low_lim: LOW_RST, temp: TEMP_RST,
                                     cmd: RESERVED_CMD, alert_n: 1'b1, default: '0};

endpackage

// [src/tsens_sync.sv]
// Four-bit two-stage synchroniser for signals entering a clock domain.
`timescale 1ns/1ps
module tsens_sync
  import tsens_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [3:0] d,
  output logic      [3:0] q
);

  tsens_sync_t s_q;
  tsens_sync_t s_d;

  // The first stage feeds only the second stage, never any logic.
  always_comb begin
    s_d        = s_q;
    s_d.meta   = d;
    s_d.stable = s_q.meta;
  end

  // No reset here: the reset itself travels through this stage.
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign q = s_q.stable;

endmodule

// [src/tsens_top.sv]
// SMBus thermal sensor command block: link engine, registers, conversion timer and alert.
`timescale 1ns/1ps
module tsens_top
  import tsens_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DEF
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        smb_clk,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire tsens_conv_t conv_res,
  output logic             conv_run,
  output logic             thermal_alert_n
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tsens_lnk_t l_q;
  tsens_lnk_t l_d;
  tsens_ref_t r_q;
  tsens_ref_t r_d;
  logic [3:0] pin_s;
  logic [3:0] req_s;
  logic       scl;
  logic       sda;
  logic       lnk_rst;
  logic       rise;
  logic       fall;
  logic       start_ev;
  logic       stop_ev;
  logic [7:0] rx_byte;
  logic       cmd_ev;
  logic       wr_ev;
  logic       rd_ev;
  logic       ara_ev;
  logic       standby;
  logic       hi_now;
  logic       lo_now;
  logic       hi_new;
  logic       lo_new;
  logic       tick_wrap;
  logic       expire;
  logic [7:0] status_byte;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [7:0] rate_slots(input logic [7:0] rate);
    logic [2:0] e;
    e = (rate > RATE_MAX) ? RATE_MAX[2:0] : rate[2:0];
    return 8'h01 << (3'h7 - e);
  endfunction

  function automatic logic [7:0] read_sel(input logic [7:0] c, input tsens_ref_t r,
                                          input logic [7:0] st);
    logic [7:0] v;
    v = 8'h00;
    case (c)
      READ_TEMP_CMD:       v = r.temp;
      READ_STATUS_CMD:     v = st;
      READ_CONFIG_CMD:     v = r.config_reg;
      READ_RATE_CMD:       v = r.rate;
      READ_HIGH_LIMIT_CMD: v = r.high_lim;
      READ_LOW_LIMIT_CMD:  v = r.low_lim;
      default:             v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Crossings
  // ****************************************************************
  // Pins, reset and the read answer toggle enter the link domain.
  tsens_sync u_sync_lnk (
    .clk (smb_clk),
    .d   ({r_q.rd_ack, rst, sda_i, scl_i}),
    .q   (pin_s)
  );

  // Request toggles from the link enter the register domain.
  tsens_sync u_sync_ref (
    .clk (ref_clk),
    .d   (l_q.tog),
    .q   (req_s)
  );

  // ****************************************************************
  // Link engine on the SMBus clock
  // ****************************************************************
  assign scl      = pin_s[PIN_SCL];
  assign sda      = pin_s[PIN_SDA];
  assign lnk_rst  = pin_s[PIN_RST];
  assign rise     = scl && !l_q.scl_d;
  assign fall     = !scl && l_q.scl_d;
  assign start_ev = scl && l_q.scl_d && l_q.sda_d && !sda;
  assign stop_ev  = scl && l_q.scl_d && !l_q.sda_d && sda;
  assign rx_byte  = {l_q.shift[6:0], sda};

  always_comb begin
    l_d       = l_q;
    l_d.scl_d = scl;
    l_d.sda_d = sda;
    l_d.sda_o = 1'b0;
    // Data words stay put in the sending register until the next request.
    if (pin_s[PIN_RDACK] != l_q.rdack_seen) begin
      l_d.rdack_seen = pin_s[PIN_RDACK];
      if (l_q.state != LS_TX) begin
        l_d.tx = r_q.rd_data;
      end
    end
    case (l_q.state)
      LS_ADDR: begin
        if (rise) begin
          l_d.shift  = rx_byte;
          l_d.bitcnt = 4'(l_q.bitcnt + 4'h1);
          if (l_q.bitcnt == 4'h7) begin
            if (rx_byte[7:1] == OWN_ADDR) begin
              l_d.state   = LS_ACK;
              l_d.is_read = rx_byte[0];
              l_d.first   = 1'b1;
              if (rx_byte[0]) begin
                l_d.tog[TOG_RD] = !l_q.tog[TOG_RD];
              end
            end else if (rx_byte[7:1] == ARA_ADDR && rx_byte[0]) begin
              l_d.state        = LS_ACK;
              l_d.is_read      = 1'b1;
              l_d.tx           = ARA_REPLY;
              l_d.tog[TOG_ARA] = !l_q.tog[TOG_ARA];
            end else begin
              l_d.state = LS_WAIT;
            end
          end
        end
      end
      LS_ACK: begin
        if (fall) begin
          if (!l_q.ack_drive) begin
            l_d.sda_oe    = 1'b1;
            l_d.ack_drive = 1'b1;
          end else begin
            l_d.ack_drive = 1'b0;
            l_d.bitcnt    = 4'h0;
            if (l_q.is_read) begin
              l_d.state  = LS_TX;
              l_d.sda_oe = !l_q.tx[7];
              l_d.tx     = {l_q.tx[6:0], 1'b0};
            end else begin
              l_d.state  = LS_RX;
              l_d.sda_oe = 1'b0;
            end
          end
        end
      end
      LS_RX: begin
        if (rise) begin
          l_d.shift  = rx_byte;
          l_d.bitcnt = 4'(l_q.bitcnt + 4'h1);
          if (l_q.bitcnt == 4'h7) begin
            l_d.state = LS_ACK;
            if (l_q.first) begin
              l_d.cmd_byte     = rx_byte;
              l_d.first        = 1'b0;
              l_d.tog[TOG_CMD] = !l_q.tog[TOG_CMD];
            end else begin
              l_d.wr_byte     = rx_byte;
              l_d.tog[TOG_WR] = !l_q.tog[TOG_WR];
            end
          end
        end
      end
      LS_TX: begin
        if (rise) begin
          l_d.bitcnt = 4'(l_q.bitcnt + 4'h1);
        end
        // one byte out, then release for the nack
        if (fall) begin
          if (l_q.bitcnt == 4'h8) begin
            l_d.sda_oe = 1'b0;
            l_d.state  = LS_WAIT;
          end else begin
            l_d.sda_oe = !l_q.tx[7];
            l_d.tx     = {l_q.tx[6:0], 1'b0};
          end
        end
      end
      LS_IDLE, LS_WAIT: begin
        l_d.sda_oe = 1'b0;
      end
      default: begin
        l_d.state = LS_IDLE;
      end
    endcase
    // A repeated start keeps the stored command in the register domain.
    if (start_ev) begin
      l_d.state     = LS_ADDR;
      l_d.bitcnt    = 4'h0;
      l_d.sda_oe    = 1'b0;
      l_d.ack_drive = 1'b0;
    end else if (stop_ev) begin
      l_d.state  = LS_IDLE;
      l_d.sda_oe = 1'b0;
    end
    if (lnk_rst) begin
      l_d = LNK_RST;
    end
  end

  always_ff @(posedge smb_clk) begin
    l_q <= l_d;
  end

  // ****************************************************************
  // Registers, conversion control and alert on the reference clock
  // ****************************************************************
  assign cmd_ev  = req_s[TOG_CMD] ^ r_q.seen[TOG_CMD];
  assign wr_ev   = req_s[TOG_WR] ^ r_q.seen[TOG_WR];
  assign rd_ev   = req_s[TOG_RD] ^ r_q.seen[TOG_RD];
  assign ara_ev  = req_s[TOG_ARA] ^ r_q.seen[TOG_ARA];
  assign standby = r_q.config_reg[STANDBY_BIT];
  assign hi_now  = $signed(r_q.temp) >= $signed(r_q.high_lim);
  assign lo_now  = $signed(r_q.temp) <= $signed(r_q.low_lim);
  assign hi_new  = $signed(conv_res.temp) >= $signed(r_q.high_lim);
  assign lo_new  = $signed(conv_res.temp) <= $signed(r_q.low_lim);
  assign tick_wrap = r_q.tick_cnt == 32'(TICK_CYC - 1);
  assign expire    = tick_wrap && (8'(r_q.slot_cnt + 8'h01) >= rate_slots(r_q.rate));

  always_comb begin
    status_byte              = 8'h00;
    status_byte[ST_BUSY_BIT] = r_q.busy;
    status_byte[ST_HIGH_BIT] = r_q.alarm_hi;
    status_byte[ST_LOW_BIT]  = r_q.alarm_lo;
    status_byte[ST_OPEN_BIT] = r_q.open_flag;
  end

  always_comb begin
    r_d      = r_q;
    r_d.seen = req_s;
    if (tick_wrap) begin
      r_d.tick_cnt = 32'h0;
      r_d.slot_cnt = expire ? 8'h00 : 8'(r_q.slot_cnt + 8'h01);
    end else begin
      r_d.tick_cnt = 32'(r_q.tick_cnt + 32'h1);
    end
    if (expire && !standby && !r_q.busy) begin
      r_d.busy = 1'b1;
    end
    if (cmd_ev) begin
      r_d.cmd = l_q.cmd_byte;
      if (l_q.cmd_byte == SINGLE_CONVERSION_CMD && !r_q.busy) begin
        r_d.busy = 1'b1;
        if (!standby) begin
          r_d.tick_cnt = 32'h0;
          r_d.slot_cnt = 8'h00;
        end
      end
    end
    if (rd_ev) begin
      r_d.rd_data = read_sel(r_q.cmd, r_q, status_byte);
      r_d.rd_ack  = !r_q.rd_ack;
      if (r_q.cmd == READ_STATUS_CMD) begin
        r_d.alarm_hi = hi_now;
        r_d.alarm_lo = lo_now;
      end
    end
    if (wr_ev) begin
      case (r_q.cmd)
        WRITE_CONFIG_CMD: begin
          r_d.config_reg = l_q.wr_byte;
          if (l_q.wr_byte[STANDBY_BIT]) begin
            r_d.busy = 1'b0;
          end
        end
        WRITE_RATE_CMD:       r_d.rate     = l_q.wr_byte;
        WRITE_HIGH_LIMIT_CMD: r_d.high_lim = l_q.wr_byte;
        WRITE_LOW_LIMIT_CMD:  r_d.low_lim  = l_q.wr_byte;
        default:              r_d.cmd      = r_q.cmd;
      endcase
    end
    // only the alert response releases the latch
    if (ara_ev) begin
      r_d.alert_n = 1'b1;
    end
    // Completion comes last so that a new alarm beats a clear in the same cycle.
    // conversion ends, standby resumes
    if (conv_res.done && r_q.busy && r_d.busy) begin
      r_d.busy      = 1'b0;
      r_d.temp      = conv_res.temp;
      r_d.open_flag = conv_res.open;
      if (hi_new) begin
        r_d.alarm_hi = 1'b1;
        r_d.alert_n  = 1'b0;
      end
      if (lo_new) begin
        r_d.alarm_lo = 1'b1;
        r_d.alert_n  = 1'b0;
      end
    end
    if (rst) begin
      r_d = REF_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    r_q <= r_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sda_o           = l_q.sda_o;
  assign sda_oe          = l_q.sda_oe;
  assign conv_run        = r_q.busy;
  assign thermal_alert_n = r_q.alert_n;

endmodule

// [bench/tsens_checker.sv]
// Port-level assertions for the thermal sensor command block.
`timescale 1ns/1ps
module tsens_checker
  import tsens_pkg::*;
#(
  parameter int unsigned TICK_CYC = 20
)
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        smb_clk,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire tsens_conv_t conv_res,
  input wire logic        conv_run,
  input wire logic        thermal_alert_n
);
  // ********************
  // Link side
  // ********************
  a_drive_only_low: assert property (@(posedge smb_clk) disable iff (rst)
    sda_oe |-> !sda_o) else $error("sda driven high");
  a_ack_in_low: assert property (@(posedge smb_clk) disable iff (rst)
    $rose(sda_oe) |-> !scl_i && !$past(scl_i, 2)) else $error("sda pulled outside low phase");
  a_release_in_low: assert property (@(posedge smb_clk) disable iff (rst)
    $fell(sda_oe) |-> !scl_i && !$past(scl_i, 2)) else $error("sda freed outside low phase");
  // Any change while SCL is high would look like a start or stop to the host.
  a_oe_steady_high: assert property (@(posedge smb_clk) disable iff (rst)
    scl_i && $past(scl_i) |-> $stable(sda_oe)) else $error("sda moved while scl high");
  // ********************
  // Register side
  // ********************
  a_run_ends_done: assert property (@(posedge ref_clk) disable iff (rst)
    conv_run && conv_res.done |=> !conv_run) else $error("conversion kept running");
  a_alert_from_conv: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(thermal_alert_n) |-> $past(conv_run) && $past(conv_res.done))
    else $error("alert without conversion");
  a_alert_free_ara: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(thermal_alert_n) |-> scl_i) else $error("alert freed off a bus bit");
  a_run_falls_cause: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(conv_run) |-> $past(conv_res.done) || scl_i) else $error("conversion dropped");
  c_ack: cover property (@(posedge smb_clk) disable iff (rst) $rose(sda_oe));
  c_alert: cover property (@(posedge ref_clk) disable iff (rst) $fell(thermal_alert_n));
  c_conv: cover property (@(posedge ref_clk) disable iff (rst) conv_run && conv_res.done);
endmodule

bind tsens_top tsens_checker #(.TICK_CYC(TICK_CYC)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .smb_clk(smb_clk), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .conv_res(conv_res), .conv_run(conv_run), .thermal_alert_n(thermal_alert_n));

// [bench/tsens_smb_host.sv]
// SMBus host controller model with open-drain data and idle-high clock.
`timescale 1ns/1ps
module tsens_smb_host
  import tsens_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // A 240 ns bit gives 120 ns clock phases, above the crossing margin, and a short run.
  localparam time T = 60ns;
  int nak_cnt = 0;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start_c();
    @(posedge ref_clk);
    #1 sda_pull = 1'b0;
    #T scl = 1'b1;
    #T sda_pull = 1'b1;
    #T scl = 1'b0;
    #T;
  endtask
  task automatic stop_c();
    sda_pull = 1'b1;
    #T scl = 1'b1;
    #T sda_pull = 1'b0;
    #T;
  endtask
  // Eight bits MSB first plus the acknowledge slot.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_pull = !tx[i];
      #T scl = 1'b1;
      #T rx[i] = sda;
      #T scl = 1'b0;
      #T;
    end
  endtask
  task automatic put(input logic [7:0] b);
    logic [8:0] r;
    xfer({b, 1'b1}, r);
    if (r[0] !== 1'b0) nak_cnt++;
  endtask
  // Last byte read is always refused so the device lets go before stop.
  task automatic get(output logic [7:0] d);
    logic [8:0] r;
    xfer(9'h1ff, r);
    d = r[8:1];
  endtask
  task automatic write_byte(input logic [7:0] c, input logic [7:0] d);
    start_c();
    put({OWN_ADDR, 1'b0});
    put(c);
    put(d);
    stop_c();
  endtask
  // send byte carries the one-shot code only.
  task automatic send_oneshot();
    start_c();
    put({OWN_ADDR, 1'b0});
    put(SINGLE_CONVERSION_CMD);
    stop_c();
  endtask
  task automatic read_byte(input logic [7:0] c, output logic [7:0] d);
    start_c();
    put({OWN_ADDR, 1'b0});
    put(c);
    start_c();
    put({OWN_ADDR, 1'b1});
    get(d);
    stop_c();
  endtask
  // receive byte, also used at the alert response address.
  task automatic recv(input logic [6:0] a, output logic [7:0] d);
    start_c();
    put({a, 1'b1});
    get(d);
    stop_c();
  endtask
endmodule

// [bench/tsens_bench.sv]
// Self-checking bench: host model, converter stand-in, directed and random traffic.
`timescale 1ns/1ps
module tsens_bench
  import tsens_pkg::*;
;
  localparam int unsigned TICK = 20;
  logic        ref_clk = 1'b0;
  logic        smb_clk = 1'b0;
  logic        rst = 1'b1;
  logic        scl;
  logic        host_pull;
  logic        sda_oe;
  logic        sda_o;
  logic        conv_run;
  logic        thermal_alert_n;
  tsens_conv_t conv_res = '0;
  wire logic   sda_w;
  int          err_count = 0;
  int          n_compared = 0;
  int          conv_delay = 5;
  int          n_runs = 0;
  int          r0;
  logic [7:0]  conv_temp = 8'h00;
  logic        conv_open = 1'b0;
  logic [7:0]  rd;
  logic [7:0]  wv [4];
  logic [7:0]  rcmd [4] = '{READ_CONFIG_CMD, READ_RATE_CMD, READ_HIGH_LIMIT_CMD,
                            READ_LOW_LIMIT_CMD};
  logic [7:0]  wcmd [4] = '{WRITE_CONFIG_CMD, WRITE_RATE_CMD, WRITE_HIGH_LIMIT_CMD,
                            WRITE_LOW_LIMIT_CMD};
  logic [7:0]  rstv [4] = '{CONFIG_RST, RATE_RST, HIGH_RST, LOW_RST};
  logic [7:0]  hot [2] = '{8'h50, 8'h80};

  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #3 smb_clk = ~smb_clk;
  end
  assign sda_w = ~host_pull & ~(sda_oe & ~sda_o);

  tsens_top #(.TICK_CYC(TICK)) dut (.ref_clk(ref_clk), .rst(rst), .smb_clk(smb_clk),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .conv_res(conv_res),
    .conv_run(conv_run), .thermal_alert_n(thermal_alert_n));
  tsens_smb_host host (.ref_clk(ref_clk), .sda(sda_w), .scl(scl), .sda_pull(host_pull));

  // Converter stand-in; temperature is only meaningful with the done pulse.
  always @(posedge conv_run) n_runs++;
  initial forever begin
    wait (conv_run === 1'b1);
    repeat (conv_delay) @(posedge ref_clk);
    #1 conv_res = '{done: 1'b1, open: conv_open, temp: conv_temp};
    @(posedge ref_clk);
    #1 conv_res = '{done: 1'b0, open: 1'b0, temp: ~conv_temp};
  end

  function automatic logic [7:0] exp_flags(input logic [7:0] t, input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [7:0] f;
    f = 8'h00;
    f[ST_HIGH_BIT] = $signed(t) >= $signed(hi);
    f[ST_LOW_BIT] = $signed(t) <= $signed(lo);
    return f;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic conv_wait();
    int n;
    n = 0;
    while (conv_run !== 1'b0 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    chk({7'h0, conv_run}, 8'h00);
    repeat (4) @(posedge ref_clk);
  endtask

  // The run needs about 0.3 ms; a fifth more than that means a hang.
  initial begin
    #360us;
    err_count++;
    end_sim();
  end

  initial begin
    void'($urandom(59));
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (10) @(posedge ref_clk);
    host.recv(OWN_ADDR, rd);
    chk(rd, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.read_byte(rcmd[i], rd);
      chk(rd, rstv[i]);
    end
    host.recv(OWN_ADDR ^ 7'h01, rd);
    chk(rd, 8'hff);
    wv = '{8'h40, 8'($urandom) & RATE_MAX, 8'($urandom), 8'($urandom)};
    for (int i = 0; i < 4; i++) host.write_byte(wcmd[i], wv[i]);
    for (int i = 0; i < 4; i++) begin
      host.read_byte(rcmd[i], rd);
      chk(rd, wv[i]);
    end
    host.recv(OWN_ADDR, rd);
    chk(rd, wv[3]);
    host.write_byte(8'h05, 8'($urandom));
    host.write_byte(READ_TEMP_CMD, 8'($urandom));
    host.read_byte(READ_HIGH_LIMIT_CMD, rd);
    chk(rd, wv[2]);
    host.read_byte(READ_TEMP_CMD, rd);
    chk(rd, conv_temp);
    host.write_byte(WRITE_HIGH_LIMIT_CMD, 8'h40);
    host.write_byte(WRITE_LOW_LIMIT_CMD, 8'h80);
    conv_temp = 8'($urandom) & 8'h3f;
    conv_delay = 6000;
    r0 = n_runs;
    host.send_oneshot();
    chk({7'h0, conv_run}, 8'h01);
    host.send_oneshot();
    host.read_byte(READ_STATUS_CMD, rd);
    chk(rd, 8'h80);
    conv_wait();
    repeat (300) @(posedge ref_clk);
    chk(8'(n_runs - r0), 8'h01);
    host.read_byte(READ_TEMP_CMD, rd);
    chk(rd, conv_temp);
    conv_delay = 10;
    for (int i = 0; i < 2; i++) begin
      conv_temp = hot[i];
      conv_open = (i == 0);
      host.send_oneshot();
      conv_wait();
      chk({7'h0, thermal_alert_n}, 8'h00);
      host.read_byte(READ_STATUS_CMD, rd);
      chk(rd, exp_flags(hot[i], 8'h40, 8'h80) | (8'(conv_open) << ST_OPEN_BIT));
      conv_temp = 8'h10;
      conv_open = 1'b0;
      host.send_oneshot();
      conv_wait();
      host.read_byte(READ_STATUS_CMD, rd);
      chk(rd, exp_flags(hot[i], 8'h40, 8'h80));
      host.recv(OWN_ADDR, rd);
      chk(rd, exp_flags(8'h10, 8'h40, 8'h80));
      chk({7'h0, thermal_alert_n}, 8'h00);
      host.recv(ARA_ADDR, rd);
      chk(rd, ARA_REPLY);
      chk({7'h0, thermal_alert_n}, 8'h01);
    end
    r0 = n_runs;
    host.write_byte(WRITE_RATE_CMD, RATE_MAX);
    host.write_byte(WRITE_CONFIG_CMD, 8'h00);
    repeat (400) @(posedge ref_clk);
    chk(8'(n_runs - r0 > 4), 8'h01);
    host.write_byte(WRITE_CONFIG_CMD, 8'h40);
    r0 = n_runs;
    repeat (400) @(posedge ref_clk);
    chk(8'(n_runs - r0), 8'h00);
    chk(8'(host.nak_cnt), 8'h01);
    end_sim();
  end
endmodule
